// ==== inc/adc_pkg.sv ====
// ============================================================
// Shared constants and carriers for the diagnostic/calibration sequencer
package adc_pkg;
   // ============================================================
   // Clock and calibration waveform times
   localparam int ADC_CLK_HZ = 100_000_000;          // System clock rate
   localparam int ADC_CYC_PER_MS = ADC_CLK_HZ / 1000; // Cycles per millisecond
   localparam int ADC_CAL_T0_MS = 250;                // Code 0 waveform, ms
   localparam int ADC_CAL_T1_MS = 500;                // Code 1 waveform, ms
   localparam int ADC_CAL_T2_S = 1;                   // Code 2 waveform, s
   localparam int ADC_CAL_CYC0 = ADC_CAL_T0_MS * ADC_CYC_PER_MS;
   localparam int ADC_CAL_CYC1 = ADC_CAL_T1_MS * ADC_CYC_PER_MS;
   localparam int ADC_CAL_CYC2 = ADC_CAL_T2_S * 1000 * ADC_CYC_PER_MS;

   // ============================================================
   // Register byte offsets
   localparam logic [4:0] ADC_OFS_CTRL = 5'h00;
   localparam logic [4:0] ADC_OFS_STAT = 5'h04;
   localparam logic [4:0] ADC_OFS_CAL_IN = 5'h08;
   localparam logic [4:0] ADC_OFS_CAL_OUT = 5'h0c;
   localparam logic [4:0] ADC_OFS_IMPED = 5'h10;
   localparam logic [4:0] ADC_OFS_AMPL = 5'h14;
   localparam logic [4:0] ADC_OFS_DRIVE = 5'h18;

   // ============================================================
   // Field encodings
   localparam logic [1:0] ADC_MODE_RTP = 2'h0;  // Real-time playback
   localparam logic [1:0] ADC_MODE_SEQ = 2'h1;  // Sequenced playback
   localparam logic [1:0] ADC_MODE_DIAG = 2'h2; // Actuator diagnostic
   localparam logic [1:0] ADC_MODE_CAL = 2'h3;  // Automatic calibration
   localparam logic [1:0] ADC_TRIG_PULSE = 2'h0; // Pin edges start and stop
   localparam logic [1:0] ADC_TRIG_LEVEL = 2'h1; // Pin level frames the run
   localparam logic [1:0] ADC_TRIG_INTR = 2'h2;  // Pin is not a trigger
   localparam logic [1:0] ADC_CALT_TRIG = 2'h3;  // Trigger-controlled duration

   // ============================================================
   // Carriers
   typedef struct packed {
      logic [1:0] cal_time;             // Calibration duration code
      logic open_loop;                  // 1: open-loop playback
      logic auto_brake;                 // Open-loop automatic braking
      logic [1:0] trigger_pin_function; // Pin role
      logic actuator_type_sel;          // 1: eccentric mass, 0: resonant
      logic go;                         // Launch bit
      logic [1:0] mode;                 // Operating mode
   } adc_ctrl_t;
   localparam int ADC_CTRL_W = 10;
   localparam adc_ctrl_t ADC_CTRL_RST = 10'h000;

   typedef struct packed {
      logic [1:0] zero_cross_sel;
      logic [3:0] current_dissipate_sel;
      logic [3:0] bemf_blank_sel;
      logic [1:0] sample_time;
      logic [1:0] feedback_gain;
      logic [2:0] feedback_brake_factor;
   } adc_cal_in_t;
   localparam int ADC_CAL_IN_W = 17;
   localparam adc_cal_in_t ADC_CAL_IN_RST = 17'h00000;

   typedef struct packed {
      logic [1:0] bemf_gain; // Resonant-actuator result only
      logic [7:0] bemf_comp;
      logic [7:0] level_comp;
   } adc_cal_out_t;
   localparam int ADC_CAL_OUT_W = 18;
   localparam adc_cal_out_t ADC_CAL_OUT_RST = 18'h00000;

   typedef struct packed {
      logic supply_low_lockout;
      logic over_temp;
      logic over_current;
   } adc_flt_t;

   typedef struct packed {
      logic short_det;
      logic open_det;
      logic bemf_ok;
   } adc_func_t;

   typedef struct packed {
      logic reverse;   // Drive with inverted direction
      logic brake;     // Brake request
      logic [7:0] mag; // Drive magnitude
   } adc_drive_t;

   typedef enum logic [3:0] {
      ADC_ST_IDLE = 4'b0001,
      ADC_ST_MEAS = 4'b0010,
      ADC_ST_FUNC = 4'b0100,
      ADC_ST_CAL = 4'b1000
   } adc_state_t;
endpackage

// ==== rtl/adc_seq.sv ====
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Diagnostic mode plus launch runs diagnostic
// - Fail flag set when actuator unusable
// - Supply/thermal/current abort sets fail flag
// - Resistance measurement first, then functional test
// - Diagnostic stores impedance unless aborted during measurement
// - Thermal or supply fault aborts to standby
// - Measurement never fails, ignores over-current
// - Functional test fails on short, open, back-EMF
// - Calibration end overwrites output parameters
// - Eccentric-mass type ignores resonant inputs
// - Duration code picks 250ms, 500ms, 1s, trigger
// - Code 3 runs start trigger to stop
// - Launch bit or configured pin triggers
// - Mode value 3 selects calibration
// - Launch bit self-clears after calibration
// - Settings kept in standby and enable low
// - Amplitude words are signed two's complement
// - Closed loop: positive drives, negative brakes
// - Open loop signed; auto-brake makes negatives brake
module adc_seq import adc_pkg::*; #(
   parameter int CAL_CYC0 = ADC_CAL_CYC0, // 250 ms waveform
   parameter int CAL_CYC1 = ADC_CAL_CYC1, // 500 ms waveform
   parameter int CAL_CYC2 = ADC_CAL_CYC2  // 1 s waveform
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic trig_pin,
   input wire adc_flt_t faults,
   input wire logic meas_done,
   input wire logic [7:0] meas_z,
   input wire logic func_done,
   input wire adc_func_t func_res,
   input wire adc_cal_out_t cal_res,
   output logic meas_req,
   output logic func_req,
   output logic cal_req,
   output adc_cal_in_t cal_eng_in,
   output adc_drive_t drive,
   output logic busy
);
   // ============================================================
   // State
   adc_state_t st_q, st_d;            // Sequencer state
   adc_ctrl_t ctrl_q;                 // Control register
   adc_cal_in_t cal_in_q;             // Calibration inputs
   adc_cal_out_t cal_out_q;           // Calibration results
   logic [7:0] imp_q;                 // Measured impedance
   logic signed [7:0] amp_q;          // Playback amplitude word
   logic fail_q;                      // Diagnostic fail flag
   logic trig_q;                      // Previous pin sample
   logic [31:0] cnt_q;                // Calibration waveform timer
   logic wait_q;                      // Waitrequest flop
   logic [31:0] rdata_q;              // Read data flop
   logic meas_req_q, func_req_q, cal_req_q, busy_q;
   adc_cal_in_t eng_q;                // Inputs shown to the engine
   adc_drive_t drv_q;                 // Interpreted drive command

   // ============================================================
   // Bus decode
   // Access completes at the edge where waitrequest is low
   wire acc = (avs_read | avs_write) & ~wait_q;
   wire wr_en = acc & avs_write;
   wire wr_ctrl = wr_en & (avs_address == ADC_OFS_CTRL);
   wire wr_cal_in = wr_en & (avs_address == ADC_OFS_CAL_IN);
   wire wr_cal_out = wr_en & (avs_address == ADC_OFS_CAL_OUT);
   wire wr_amp = wr_en & (avs_address == ADC_OFS_AMPL);
   wire adc_ctrl_t wctl = adc_ctrl_t'(avs_writedata[ADC_CTRL_W-1:0]);

   // ============================================================
   // Trigger and launch decode
   wire idle = (st_q == ADC_ST_IDLE);
   wire pin_trig = (ctrl_q.trigger_pin_function != ADC_TRIG_INTR);
   wire trig_rise = trig_pin & ~trig_q;
   wire trig_fall = ~trig_pin & trig_q;
   wire lvl_mode = (ctrl_q.trigger_pin_function == ADC_TRIG_LEVEL);
   wire ext_stop = pin_trig & (lvl_mode ? trig_fall : trig_rise);
   wire trig_cal = (ctrl_q.mode == ADC_MODE_CAL) & (ctrl_q.cal_time == ADC_CALT_TRIG);
   // Pin may only start a trigger-controlled calibration
   wire ext_start = idle & pin_trig & trig_rise & trig_cal;
   wire go_w1 = wr_ctrl & wctl.go;
   wire go_w0 = wr_ctrl & ~wctl.go;
   // Mode written together with the launch bit counts at once
   wire [1:0] mode_new = wr_ctrl ? wctl.mode : ctrl_q.mode;
   wire launch = idle & (go_w1 | ext_start);
   wire start_diag = launch & (mode_new == ADC_MODE_DIAG);
   wire start_cal = launch & (mode_new == ADC_MODE_CAL);
   wire hard_flt = faults.supply_low_lockout | faults.over_temp;
   wire any_flt = hard_flt | faults.over_current;

   // ============================================================
   // Calibration timing
   wire [1:0] ct = ctrl_q.cal_time;
   wire timed = (ct != ADC_CALT_TRIG);
   wire [31:0] lim = (ct == 2'h0) ? 32'(CAL_CYC0) :
                     (ct == 2'h1) ? 32'(CAL_CYC1) : 32'(CAL_CYC2);
   // Code 3: a launch-bit clear or a pin stop trigger ends the run
   wire cal_end = timed ? (cnt_q == lim - 32'h1) : (go_w0 | ext_stop);
   wire func_bad = func_res.short_det | func_res.open_det | ~func_res.bemf_ok;

   // ============================================================
   // Next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         ADC_ST_IDLE: begin
            if (start_diag) begin
               st_d = ADC_ST_MEAS;
            end else if (start_cal) begin
               st_d = ADC_ST_CAL;
            end
         end
         // Over-current cannot arise from the small sense current
         ADC_ST_MEAS: begin
            if (hard_flt) begin
               st_d = ADC_ST_IDLE;
            end else if (meas_done) begin
               st_d = ADC_ST_FUNC;
            end
         end
         ADC_ST_FUNC: begin
            if (any_flt | func_done) begin
               st_d = ADC_ST_IDLE;
            end
         end
         ADC_ST_CAL: begin
            if (any_flt | cal_end) begin
               st_d = ADC_ST_IDLE;
            end
         end
         default: st_d = ADC_ST_IDLE;
      endcase
   end

   // Fail events: aborts and a bad functional result
   wire fail_set = (st_q == ADC_ST_MEAS & hard_flt) |
                   (st_q == ADC_ST_FUNC & (any_flt | (func_done & func_bad))) |
                   (st_q == ADC_ST_CAL & any_flt);
   wire cal_ok = (st_q == ADC_ST_CAL) & cal_end & ~any_flt;
   wire finish = ~idle & (st_d == ADC_ST_IDLE);

   // ============================================================
   // Sequencer flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= ADC_ST_IDLE;
         trig_q <= 1'b0;
         cnt_q <= 32'h0;
      end else begin
         st_q <= st_d;
         trig_q <= trig_pin;
         cnt_q <= (st_q == ADC_ST_CAL) ? cnt_q + 32'h1 : 32'h0;
      end
   end

   // Fail flag: cleared by a diagnostic or calibration launch, set by hardware only
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fail_q <= 1'b0;
      end else if (fail_set) begin
         fail_q <= 1'b1;
      end else if (launch & (start_diag | start_cal)) begin
         fail_q <= 1'b0;
      end
   end

   // ============================================================
   // Control register; the enable pin does not touch it
   // Other fields are frozen while a routine runs, so a stray write
   // cannot change the duration or mode mid-run
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= ADC_CTRL_RST;
      end else if (finish) begin
         ctrl_q.go <= 1'b0;
      end else if (wr_ctrl & idle) begin
         ctrl_q <= wctl;
      end else if (ext_start) begin
         ctrl_q.go <= 1'b1;
      end
   end

   // Calibration inputs and results, impedance, amplitude
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cal_in_q <= ADC_CAL_IN_RST;
         cal_out_q <= ADC_CAL_OUT_RST;
         imp_q <= 8'h00;
         amp_q <= 8'sh00;
      end else begin
         if (wr_cal_in & idle) begin
            cal_in_q <= adc_cal_in_t'(avs_writedata[ADC_CAL_IN_W-1:0]);
         end
         // Host may restore saved results while idle
         if (cal_ok) begin
            cal_out_q.level_comp <= cal_res.level_comp;
            cal_out_q.bemf_comp <= cal_res.bemf_comp;
            if (!ctrl_q.actuator_type_sel) begin
               cal_out_q.bemf_gain <= cal_res.bemf_gain;
            end
         end else if (wr_cal_out & idle) begin
            cal_out_q <= adc_cal_out_t'(avs_writedata[ADC_CAL_OUT_W-1:0]);
         end
         if ((st_q == ADC_ST_MEAS) & meas_done & ~hard_flt) begin
            imp_q <= meas_z;
         end
         if (wr_amp) begin
            amp_q <= avs_writedata[7:0];
         end
      end
   end

   // ============================================================
   // Amplitude interpretation
   wire play = idle & ctrl_q.go & ~ctrl_q.mode[1];
   wire neg = amp_q[7];
   wire [7:0] amp_abs = neg ? 8'(-amp_q) : amp_q;
   // Closed loop brakes automatically; open loop needs auto_brake
   wire brk = neg & (~ctrl_q.open_loop | ctrl_q.auto_brake);
   wire rev = neg & ctrl_q.open_loop & ~ctrl_q.auto_brake;
   wire [7:0] mag = (neg & ~ctrl_q.open_loop) ? 8'h00 : amp_abs;
   wire adc_drive_t drv_d = play ? {rev, brk, mag} : '0;
   // Eccentric-mass calibration sees the resonant inputs as zero
   wire adc_cal_in_t eng_d = ctrl_q.actuator_type_sel ?
      {2'h0, 4'h0, 4'h0, 2'h0, cal_in_q.feedback_gain, cal_in_q.feedback_brake_factor} :
      cal_in_q;

   // ============================================================
   // Outputs and bus answer
   wire [31:0] rd_mux =
      (avs_address == ADC_OFS_CTRL) ? 32'(ctrl_q) :
      (avs_address == ADC_OFS_STAT) ? {26'h0, st_q, ~idle, fail_q} :
      (avs_address == ADC_OFS_CAL_IN) ? 32'(cal_in_q) :
      (avs_address == ADC_OFS_CAL_OUT) ? 32'(cal_out_q) :
      (avs_address == ADC_OFS_IMPED) ? {24'h0, imp_q} :
      (avs_address == ADC_OFS_AMPL) ? {24'h0, amp_q} :
      (avs_address == ADC_OFS_DRIVE) ? 32'(drv_q) : 32'h0;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
         meas_req_q <= 1'b0;
         func_req_q <= 1'b0;
         cal_req_q <= 1'b0;
         busy_q <= 1'b0;
         eng_q <= ADC_CAL_IN_RST;
         drv_q <= '0;
      end else begin
         // One wait cycle, then the answer; back to wait after it
         wait_q <= ~((avs_read | avs_write) & wait_q);
         if (avs_read & wait_q) begin
            rdata_q <= rd_mux;
         end
         meas_req_q <= (st_d == ADC_ST_MEAS);
         func_req_q <= (st_d == ADC_ST_FUNC);
         cal_req_q <= (st_d == ADC_ST_CAL);
         busy_q <= (st_d != ADC_ST_IDLE);
         eng_q <= eng_d;
         drv_q <= drv_d;
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;
   assign meas_req = meas_req_q;
   assign func_req = func_req_q;
   assign cal_req = cal_req_q;
   assign busy = busy_q;
   assign cal_eng_in = eng_q;
   assign drive = drv_q;

   // ============================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_meas_ok;
      (st_q == ADC_ST_MEAS) && meas_done && !hard_flt;
   endsequence
   sequence s_cal_done;
      (st_q == ADC_ST_CAL) && cal_end && !any_flt;
   endsequence

   property p_hard_abort;
      (st_q == ADC_ST_MEAS) && hard_flt |=> fail_q && idle && !meas_req;
   endproperty
   a_hard_abort: assert property (p_hard_abort) else $error("no abort");

   property p_meas_no_fail;
      (st_q == ADC_ST_MEAS) && !hard_flt |=> !fail_q;
   endproperty
   a_meas_no_fail: assert property (p_meas_no_fail) else $error("meas set fail");

   property p_order;
      s_meas_ok |=> func_req && !meas_req && (st_q == ADC_ST_FUNC);
   endproperty
   a_order: assert property (p_order) else $error("bad phase order");

   property p_imped;
      s_meas_ok |=> imp_q == $past(meas_z);
   endproperty
   a_imped: assert property (p_imped) else $error("impedance lost");

   property p_func_fail;
      (st_q == ADC_ST_FUNC) && func_done && func_bad |=> fail_q && !busy;
   endproperty
   a_func_fail: assert property (p_func_fail) else $error("func fail missed");

   property p_cal_write;
      s_cal_done |=> cal_out_q.level_comp == $past(cal_res.level_comp) && !ctrl_q.go;
   endproperty
   a_cal_write: assert property (p_cal_write) else $error("results not written");

   property p_erm_keep;
      (s_cal_done and ctrl_q.actuator_type_sel) |=> $stable(cal_out_q.bemf_gain);
   endproperty
   a_erm_keep: assert property (p_erm_keep) else $error("erm took lra field");

   property p_timed;
      (st_q == ADC_ST_CAL) && timed && (cnt_q == lim - 32'h1) && !any_flt |=> idle;
   endproperty
   a_timed: assert property (p_timed) else $error("timed cal overran");

   property p_cb_brake;
      play && !ctrl_q.open_loop && neg |=> drive.brake && (drive.mag == 8'h00);
   endproperty
   a_cb_brake: assert property (p_cb_brake) else $error("no brake");

   property p_ol_auto;
      play && ctrl_q.open_loop && ctrl_q.auto_brake && neg |=> drive.brake && !drive.reverse;
   endproperty
   a_ol_auto: assert property (p_ol_auto) else $error("auto brake lost");

   property p_wait;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");

   // Launch, completion and retention; a clean end must clear go
   property p_diag_go;
      start_diag |=> meas_req && busy && (st_q == ADC_ST_MEAS);
   endproperty
   a_diag_go: assert property (p_diag_go) else $error("no diag start");

   property p_func_ok;
      (st_q == ADC_ST_FUNC) && func_done && !func_bad && !any_flt |=>
         idle && !fail_q && !ctrl_q.go;
   endproperty
   a_func_ok: assert property (p_func_ok) else $error("clean diag end wrong");

   property p_pin_start;
      ext_start && !wr_ctrl |=> (st_q == ADC_ST_CAL) && ctrl_q.go && cal_req;
   endproperty
   a_pin_start: assert property (p_pin_start) else $error("pin start lost");

   property p_trig_stop;
      (st_q == ADC_ST_CAL) && !timed && (ext_stop || go_w0) && !any_flt |=> idle && !ctrl_q.go;
   endproperty
   a_trig_stop: assert property (p_trig_stop) else $error("stop ignored");

   property p_keep;
      idle && !wr_en |=> $stable(cal_in_q) && $stable(cal_out_q);
   endproperty
   a_keep: assert property (p_keep) else $error("settings lost in standby");
endmodule

// ==== tb/adc_far_model.sv ====
`timescale 1ns/1ps
// ============================================================
// Far side: resistance meter, drive-test engine, calibration engine
module adc_far_model import adc_pkg::*; (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic meas_req,
   input wire logic func_req,
   input wire logic [7:0] dly,
   input wire logic [7:0] z_val,
   input wire adc_func_t f_val,
   input wire adc_cal_out_t cal_val,
   output logic meas_done,
   output logic [7:0] meas_z,
   output logic func_done,
   output adc_func_t func_res,
   output adc_cal_out_t cal_res
);
   logic [7:0] cnt_q; // Cycles spent on the current request
   logic fired_q;     // One answer per request only
   logic [1:0] req_q; // Last request pair; a change restarts the count
   // Results outside their strobe are junk, so a late sample shows up
   assign meas_z = meas_done ? z_val : ~z_val;
   assign func_res = func_done ? f_val : ~f_val;
   // Engine result is a steady level during the whole waveform
   assign cal_res = cal_val;
   // ============================================================
   // Answer each request once, dly + 2 cycles after it appears
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 8'h00;
         fired_q <= 1'b0;
         req_q <= 2'h0;
         meas_done <= 1'b0;
         func_done <= 1'b0;
      end else begin
         meas_done <= 1'b0;
         func_done <= 1'b0;
         req_q <= {meas_req, func_req};
         // Phase change: start a fresh answer
         if (req_q != {meas_req, func_req}) begin
            cnt_q <= 8'h00;
            fired_q <= 1'b0;
         end else if ((meas_req || func_req) && !fired_q) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == dly) begin
               fired_q <= 1'b1;
               meas_done <= meas_req;
               func_done <= func_req;
            end
         end
      end
   end
endmodule

// ==== tb/adc_seq_tb.sv ====
`timescale 1ns/1ps
// ============================================================
// Bench: register-level tests of the sequencer
module adc_seq_tb import adc_pkg::*; ();
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic trig_pin = 1'b0;
   adc_flt_t faults = 3'h0;
   logic meas_done, func_done, meas_req, func_req, cal_req, busy;
   logic [7:0] meas_z;
   adc_func_t func_res;
   adc_cal_out_t cal_res;
   adc_cal_in_t cal_eng_in;
   adc_drive_t drive;
   logic [7:0] z_val = 8'h20;    // Resistance the meter reports
   adc_func_t f_val = 3'h1;      // Drive-test verdict
   adc_cal_out_t cal_val = 18'h0; // Engine result
   logic saw_meas = 1'b0, saw_func = 1'b0, bad_order = 1'b0;
   int cal_cnt = 0, cyc = 0, n_errors = 0, num_checks = 0;
   logic [31:0] rd;
   adc_cal_out_t cv;
   // Playback table: control word, amplitude, expected drive
   localparam logic [7:0] PB_C [5] = '{8'h04, 8'h04, 8'h84, 8'hc4, 8'h84};
   localparam logic [7:0] PB_A [5] = '{8'h40, 8'hc0, 8'hc0, 8'hc0, 8'h80};
   localparam logic [9:0] PB_D [5] = '{10'h040, 10'h100, 10'h240, 10'h140, 10'h280};

   always #5 sys_clk = ~sys_clk;

   // Short counts keep the timed calibrations to a few dozen cycles
   adc_seq #(.CAL_CYC0(20), .CAL_CYC1(40), .CAL_CYC2(80)) i_dut (.sys_clk(sys_clk),
      .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .trig_pin(trig_pin), .faults(faults),
      .meas_done(meas_done), .meas_z(meas_z), .func_done(func_done), .func_res(func_res),
      .cal_res(cal_res), .meas_req(meas_req), .func_req(func_req), .cal_req(cal_req),
      .cal_eng_in(cal_eng_in), .drive(drive), .busy(busy));

   adc_far_model i_far (.sys_clk(sys_clk), .rstn(rstn), .meas_req(meas_req),
      .func_req(func_req), .dly(8'h0a), .z_val(z_val), .f_val(f_val), .cal_val(cal_val),
      .meas_done(meas_done), .meas_z(meas_z), .func_done(func_done), .func_res(func_res),
      .cal_res(cal_res));

   // ============================================================
   // Phase monitor, waveform length counter and hang guard
   always @(posedge sys_clk) begin
      if (meas_req === 1'b1) saw_meas <= 1'b1;
      if (func_req === 1'b1) saw_func <= 1'b1;
      // Drive test must never come before the measurement
      if (func_req === 1'b1 && saw_meas !== 1'b1) bad_order <= 1'b1;
      if (cal_req === 1'b1) cal_cnt <= cal_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // One Avalon access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge sys_clk);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   // Bounded wait: 0 busy up, 1 busy down, 2 measuring, 3 measurement over
   task automatic wait_on(input int k);
      int n;
      n = 0;
      while (!(k == 0 ? busy === 1'b1 : k == 1 ? busy === 1'b0 : k == 2 ?
             meas_req === 1'b1 : (meas_done === 1'b1 || meas_req !== 1'b1)) && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 200) chk(32'h1, 32'h0);
   endtask

   // Diagnostic run with an optional fault set for each phase
   task automatic run_diag(input adc_func_t fr, input adc_flt_t fm, input adc_flt_t ff,
      input logic fail);
      logic ab;
      ab = fm[2] | fm[1];
      f_val <= fr;
      z_val <= z_val + 8'h11;
      saw_meas <= 1'b0;
      saw_func <= 1'b0;
      bad_order <= 1'b0;
      bus(1'b1, ADC_OFS_CTRL, 32'h6, rd);
      wait_on(2);
      faults <= fm;
      wait_on(3);
      faults <= ff;
      wait_on(1);
      faults <= 3'h0;
      bus(1'b0, ADC_OFS_STAT, 32'h0, rd);
      chk(rd, 32'h4 | 32'(fail));
      bus(1'b0, ADC_OFS_CTRL, 32'h0, rd);
      chk(rd, 32'h2);
      chk(32'(saw_func), 32'(!ab));
      chk(32'(bad_order), 32'h0);
      bus(1'b0, ADC_OFS_IMPED, 32'h0, rd);
      if (!ab) chk(rd, 32'(z_val));
   endtask

   // Calibration: 0 timed, 1 launch bit framed, 2 pin pulses, 3 pin level
   task automatic run_cal(input logic [31:0] c, input int how, input int cnt,
      input adc_cal_out_t v, input adc_cal_out_t exp);
      cal_val <= v;
      cal_cnt <= 0;
      bus(1'b1, ADC_OFS_CTRL, how >= 2 ? c : c | 32'h4, rd);
      if (how >= 2) trig_pin <= 1'b1;
      if (how == 2) repeat (3) @(posedge sys_clk);
      if (how == 2) trig_pin <= 1'b0;
      wait_on(0);
      if (how != 0) begin
         // Stimulus length only; the stop comes from the bench
         repeat (80) @(posedge sys_clk);
         if (how == 1) bus(1'b1, ADC_OFS_CTRL, c, rd);
         if (how == 2) trig_pin <= 1'b1;
         if (how == 2) repeat (3) @(posedge sys_clk);
         if (how >= 2) trig_pin <= 1'b0;
      end
      wait_on(1);
      if (cnt != 0) chk(cal_cnt, cnt);
      else chk(32'(cal_cnt >= 80), 32'h1);
      bus(1'b0, ADC_OFS_CAL_OUT, 32'h0, rd);
      chk(rd, 32'(exp));
      bus(1'b0, ADC_OFS_CTRL, 32'h0, rd);
      chk(rd, c);
      bus(1'b0, ADC_OFS_STAT, 32'h0, rd);
      chk(rd, 32'h4);
   endtask

   // ============================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      chk(32'(avs_waitrequest), 32'h1);
      chk(32'(drive), 32'h0);
      rstn <= 1'b1;
      bus(1'b0, ADC_OFS_CTRL, 32'h0, rd);
      chk(rd, 32'h0);
      bus(1'b0, ADC_OFS_STAT, 32'h0, rd);
      chk(rd, 32'h4);
      // Unmapped place: write dropped, reads zero
      bus(1'b1, 5'h1c, 32'hffff_ffff, rd);
      bus(1'b0, 5'h1c, 32'h0, rd);
      chk(rd, 32'h0);
      // Typical engine inputs preloaded by the host
      bus(1'b1, ADC_OFS_CAL_IN, 32'h8f3, rd);
      bus(1'b0, ADC_OFS_CAL_IN, 32'h0, rd);
      chk(rd, 32'h8f3);
      chk(32'(cal_eng_in), 32'h8f3);
      run_diag(3'h1, 3'h1, 3'h0, 1'b0);
      run_diag(3'h5, 3'h0, 3'h0, 1'b1);
      run_diag(3'h3, 3'h0, 3'h0, 1'b1);
      run_diag(3'h0, 3'h0, 3'h0, 1'b1);
      run_diag(3'h1, 3'h4, 3'h0, 1'b1);
      run_diag(3'h1, 3'h2, 3'h0, 1'b1);
      run_diag(3'h1, 3'h0, 3'h1, 1'b1);
      for (int i = 0; i < 3; i++) begin
         cv = {2'(i + 1), 8'(8'h30 + i), 8'(8'hc0 + i)};
         run_cal(32'h3 | (32'(i) << 8), 0, 20 << i, cv, cv);
      end
      run_cal(32'h303, 1, 0, 18'h2a5a5, 18'h2a5a5);
      run_cal(32'h303, 2, 0, 18'h15a5a, 18'h15a5a);
      run_cal(32'h313, 3, 0, 18'h1c33c, 18'h1c33c);
      // Pin set to no trigger role: a rise must not start anything
      bus(1'b1, ADC_OFS_CTRL, 32'h323, rd);
      trig_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk(32'(busy), 32'h0);
      trig_pin <= 1'b0;
      // Eccentric mass: resonant-only result keeps its old value
      run_cal(32'h00b, 0, 20, 18'h2f00f, 18'h1f00f);
      chk(32'(cal_eng_in), 32'h13);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, ADC_OFS_CTRL, 32'(PB_C[i]), rd);
         bus(1'b1, ADC_OFS_AMPL, 32'(PB_A[i]), rd);
         bus(1'b0, ADC_OFS_DRIVE, 32'h0, rd);
         chk(rd, 32'(PB_D[i]));
         chk(32'(drive), 32'(PB_D[i]));
      end
      bus(1'b1, ADC_OFS_CTRL, 32'h0, rd);
      give_verdict();
   end
endmodule
